// File: logic/apd_pkg.sv
// Purpose: shared constants of the automatic power-down controller
// Assumes: one 25 MHz clock, all pins enter through two-flop synchronisers
// Notes:   power mode registers are loaded from plain write ports
package apd_pkg;
	localparam int          CNT_W         = 4;
	localparam logic [3:0]  IDLE_LIMIT    = 4'hf;
	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_STEP      = 4'h1;
	localparam int          REG_W         = 8;
	localparam logic [7:0]  PMR_RESET     = 8'h00;
	localparam int          PMR0_SLOW_BIT = 3;
	localparam int          PMR0_AUX_ARR  = 4;
	localparam int          PMR0_AUX_MCL  = 5;
	localparam int          PMR2_ADDR_LO  = 0;
	localparam int          PMR2_CTL0     = 2;
	localparam int          PMR2_CTL1     = 3;
	localparam int          PMR2_CTL2     = 4;
	localparam int          PMR2_STROBE   = 5;
	localparam int          PMR2_WRH      = 6;
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 16;
	localparam int          ADDR_LO_W     = 8;
	localparam int          CTL_W         = 3;
endpackage

// File: logic/apd_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: bits of a bus are sampled independently
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
module apd_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// File: logic/apd_idle_counter.sv
// Purpose: saturating idle counter of aux clock periods
// Assumes: tick is a one-cycle pulse per aux clock period
// Notes:   clear wins over counting
`timescale 1ns/100ps
module apd_idle_counter #(
	parameter int                     W     = apd_pkg::CNT_W,
	parameter logic [apd_pkg::CNT_W-1:0] LIMIT = apd_pkg::IDLE_LIMIT
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic         clear_i,
	input  wire logic         tick_i,
	output logic      [W-1:0] count_o
);
	always_ff @(posedge mclk_i) begin
		if (rst_i || clear_i) begin
			count_o <= apd_pkg::CNT_ZERO;
		end else if (tick_i && count_o != LIMIT) begin
			count_o <= count_o + apd_pkg::CNT_STEP;
		end
	end
endmodule

// File: logic/apd_power_ctrl.sv
// Purpose: automatic power-down unit with power mode registers
// Assumes: pins are asynchronous to mclk_i; config ports are synchronous
// Notes:   blocked bus paths hold their last value; blocked aux clock outputs are forced low
`timescale 1ns/100ps
module apd_power_ctrl (
	input  wire logic                          mclk_i,
	input  wire logic                          rst_i,
	input  wire logic                          addr_strobe_input_i,
	input  wire logic                          aux_clock_input_i,
	input  wire logic                          chip_sel_n_i,
	input  wire logic [apd_pkg::CTL_W-1:0]     bus_control_inputs_i,
	input  wire logic                          write_high_byte_strobe_i,
	input  wire logic [apd_pkg::ADDR_W-1:0]    mcu_addr_i,
	input  wire logic [apd_pkg::DATA_W-1:0]    mcu_data_i,
	input  wire logic                          main_below_stby_i,
	input  wire logic                          apd_enable_i,
	input  wire logic                          strobe_polarity_i,
	input  wire logic                          pmr0_wr_i,
	input  wire logic [apd_pkg::REG_W-1:0]     pmr0_data_i,
	input  wire logic                          pmr2_wr_i,
	input  wire logic [apd_pkg::REG_W-1:0]     pmr2_data_i,
	input  wire logic                          data_oe_req_i,
	input  wire logic                          periph_oe_req_i,
	output logic                               power_down_flag_o,
	output logic [apd_pkg::CNT_W-1:0]          idle_count_o,
	output logic [apd_pkg::REG_W-1:0]          power_mode_reg_zero_o,
	output logic [apd_pkg::REG_W-1:0]          power_mode_reg_two_o,
	output logic                               full_speed_o,
	output logic [apd_pkg::ADDR_W-1:0]         mem_addr_o,
	output logic [apd_pkg::DATA_W-1:0]         mem_data_o,
	output logic                               mem_sel_o,
	output logic [apd_pkg::ADDR_LO_W-1:0]      pld_addr_lo_o,
	output logic [apd_pkg::CTL_W-1:0]          pld_ctrl_o,
	output logic                               pld_strobe_o,
	output logic                               pld_wrh_o,
	output logic                               pld_aux_array_o,
	output logic                               pld_aux_mcell_o,
	output logic                               data_port_oe_o,
	output logic                               periph_oe_o,
	output logic                               battery_on_indicator_o
);
	logic                          strobe_s;
	logic                          aux_s;
	logic                          cs_n_s;
	logic                          bat_s;
	logic [apd_pkg::CTL_W-1:0]     ctl_s;
	logic                          wrh_s;
	logic [apd_pkg::ADDR_W-1:0]    addr_s;
	logic [apd_pkg::DATA_W-1:0]    data_s;
	logic                          strobe_prev;
	logic                          aux_prev;
	logic                          strobe_edge;
	logic                          aux_tick;
	logic                          level_idle;
	logic                          cs_sel;
	logic                          pd_exit;
	logic                          count_en;
	logic                          cnt_clear;
	logic                          next_pd;
	logic [apd_pkg::CNT_W-1:0]     cnt;

	// pin synchronisers
	apd_sync #(.W(4)) u_sync_ctl (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.d_i    ({addr_strobe_input_i, aux_clock_input_i,
			  chip_sel_n_i, main_below_stby_i}),
		.q_o    ({strobe_s, aux_s, cs_n_s, bat_s})
	);

	apd_sync #(.W(apd_pkg::CTL_W + 1)) u_sync_bus_ctl (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.d_i    ({bus_control_inputs_i, write_high_byte_strobe_i}),
		.q_o    ({ctl_s, wrh_s})
	);

	apd_sync #(.W(apd_pkg::ADDR_W + apd_pkg::DATA_W)) u_sync_ad (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.d_i    ({mcu_addr_i, mcu_data_i}),
		.q_o    ({addr_s, data_s})
	);

	// edge history of strobe and aux clock
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			strobe_prev <= 1'b0;
			aux_prev    <= 1'b0;
		end else begin
			strobe_prev <= strobe_s;
			aux_prev    <= aux_s;
		end
	end

	// aux tick is taken before any blocking bit
	assign aux_tick    = aux_s && !aux_prev;
	assign strobe_edge = strobe_s != strobe_prev;
	assign level_idle  = strobe_s == strobe_polarity_i;
	assign cs_sel      = !cs_n_s;

	// pulsing strobe, selection or disable leave power-down
	assign pd_exit   = strobe_edge || cs_sel || !apd_enable_i;
	assign count_en  = apd_enable_i && level_idle && !strobe_edge;
	assign cnt_clear = !count_en || pd_exit;

	apd_idle_counter #(
		.W     (apd_pkg::CNT_W),
		.LIMIT (apd_pkg::IDLE_LIMIT)
	) u_idle (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.clear_i (cnt_clear),
		.tick_i  (aux_tick),
		.count_o (cnt)
	);

	// entry needs the idle count at IDLE_LIMIT and no exit condition
	always_comb begin
		next_pd = power_down_flag_o;
		if (pd_exit) begin
			next_pd = 1'b0;
		end else if (cnt == apd_pkg::IDLE_LIMIT) begin
			next_pd = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			power_down_flag_o <= 1'b0;
			idle_count_o      <= apd_pkg::CNT_ZERO;
		end else begin
			power_down_flag_o <= next_pd;
			idle_count_o      <= cnt;
		end
	end

	// power mode registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			power_mode_reg_zero_o <= apd_pkg::PMR_RESET;
		end else if (pmr0_wr_i) begin
			power_mode_reg_zero_o <= pmr0_data_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			power_mode_reg_two_o <= apd_pkg::PMR_RESET;
		end else if (pmr2_wr_i) begin
			power_mode_reg_two_o <= pmr2_data_i;
		end
	end

	// logic speed ignores power-down
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			full_speed_o <= 1'b1;
		end else begin
			full_speed_o <=
				!power_mode_reg_zero_o[apd_pkg::PMR0_SLOW_BIT];
		end
	end

	// memory paths: blocked and deselected in power-down
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mem_addr_o <= '0;
			mem_data_o <= '0;
		end else if (!next_pd) begin
			mem_addr_o <= addr_s;
			mem_data_o <= data_s;
		end
	end

	// chip select gates memories only
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mem_sel_o <= 1'b0;
		end else begin
			mem_sel_o <= cs_sel && !next_pd;
		end
	end

	// low address byte to the logic arrays
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pld_addr_lo_o <= '0;
		end else if (!next_pd &&
			     !power_mode_reg_two_o[apd_pkg::PMR2_ADDR_LO]) begin
			pld_addr_lo_o <= addr_s[apd_pkg::ADDR_LO_W-1:0];
		end
	end

	// control and strobe inputs to the logic arrays
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pld_ctrl_o   <= '0;
			pld_strobe_o <= 1'b0;
			pld_wrh_o    <= 1'b0;
		end else begin
			if (!power_mode_reg_two_o[apd_pkg::PMR2_CTL0])
				pld_ctrl_o[0] <= ctl_s[0];
			if (!power_mode_reg_two_o[apd_pkg::PMR2_CTL1])
				pld_ctrl_o[1] <= ctl_s[1];
			if (!power_mode_reg_two_o[apd_pkg::PMR2_CTL2])
				pld_ctrl_o[2] <= ctl_s[2];
			if (!power_mode_reg_two_o[apd_pkg::PMR2_STROBE])
				pld_strobe_o <= strobe_s;
			if (!power_mode_reg_two_o[apd_pkg::PMR2_WRH])
				pld_wrh_o <= wrh_s;
		end
	end

	// aux clock to array and macrocells
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pld_aux_array_o <= 1'b0;
			pld_aux_mcell_o <= 1'b0;
		end else begin
			pld_aux_array_o <= aux_s &&
				!power_mode_reg_zero_o[apd_pkg::PMR0_AUX_ARR];
			pld_aux_mcell_o <= aux_s &&
				!power_mode_reg_zero_o[apd_pkg::PMR0_AUX_MCL];
		end
	end

	// pin drivers: data and peripheral ports float in power-down
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			data_port_oe_o <= 1'b0;
			periph_oe_o    <= 1'b0;
		end else begin
			data_port_oe_o <= data_oe_req_i && !next_pd;
			periph_oe_o    <= periph_oe_req_i && !next_pd;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			battery_on_indicator_o <= 1'b0;
		end else begin
			battery_on_indicator_o <= bat_s;
		end
	end

	// checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	a_pd_after_count: assert property (
		$rose(power_down_flag_o) |-> $past(cnt) == apd_pkg::IDLE_LIMIT
	) else $error("power-down raised before fifteen idle periods");

	a_count_stop_edge: assert property (
		strobe_edge |=> cnt == apd_pkg::CNT_ZERO
	) else $error("idle counter not cleared by strobe edge");

	a_count_aux_tick: assert property (
		count_en && !pd_exit && aux_tick &&
		cnt != apd_pkg::IDLE_LIMIT &&
		power_mode_reg_zero_o[apd_pkg::PMR0_AUX_ARR]
		|=> cnt == $past(cnt) + apd_pkg::CNT_STEP
	) else $error("blocked aux clock stopped idle counter");

	a_exit_on_edge: assert property (
		power_down_flag_o && strobe_edge |=> !power_down_flag_o
	) else $error("strobe activity did not end power-down");

	a_exit_on_select: assert property (
		power_down_flag_o && cs_sel |=> !power_down_flag_o
	) else $error("chip select did not end power-down");

	a_mem_deselect: assert property (
		power_down_flag_o |-> !mem_sel_o
	) else $error("memory selected during power-down");

	a_addr_blocked: assert property (
		power_down_flag_o && $past(power_down_flag_o)
		|-> $stable(mem_addr_o) && $stable(mem_data_o)
	) else $error("memory bus moved during power-down");

	a_pins_float: assert property (
		power_down_flag_o |-> !data_port_oe_o && !periph_oe_o
	) else $error("data or peripheral port driven in power-down");

	a_speed_bit: assert property (
		pmr0_wr_i ##1 1'b1 |=>
		full_speed_o == !$past(pmr0_data_i[apd_pkg::PMR0_SLOW_BIT], 2)
	) else $error("full-speed output does not follow bit 3");

	a_reset_speed: assert property (
		disable iff (1'b0) $past(rst_i) |-> full_speed_o
	) else $error("full-speed not active after reset");

	a_aux_block: assert property (
		power_mode_reg_zero_o[apd_pkg::PMR0_AUX_ARR] |=> !pld_aux_array_o
	) else $error("aux clock reached blocked logic array");

	a_addr_lo_block: assert property (
		power_mode_reg_two_o[apd_pkg::PMR2_ADDR_LO] |=>
		$stable(pld_addr_lo_o)
	) else $error("blocked low address byte reached logic");

	a_battery_flag: assert property (
		bat_s |=> battery_on_indicator_o
	) else $error("battery indicator missed supply drop");

	c_enter_pd: cover property ($rose(power_down_flag_o));
	c_exit_edge: cover property (power_down_flag_o && strobe_edge);
	c_exit_select: cover property (power_down_flag_o && cs_sel);
	c_speed_off: cover property (!full_speed_o && power_down_flag_o);
endmodule

// File: sim/apd_mcu_model.sv
// Purpose: bus side model: address strobe, aux clock, address and data
// Assumes: aux period of 8 mclk cycles, active strobe toggles every 2
// Notes:   bus values change every cycle so a frozen path shows
`timescale 1ns/100ps
module apd_mcu_model (
	input  wire logic                       mclk_i,
	input  wire logic                       active_i,
	input  wire logic                       idle_lvl_i,
	output logic                            strobe_o,
	output logic                            aux_o,
	output logic [apd_pkg::ADDR_W-1:0]      addr_o,
	output logic [apd_pkg::DATA_W-1:0]      data_o
);
	logic [3:0] ph = 4'h0;
	initial begin
		strobe_o = 1'b0;
		aux_o = 1'b0;
		addr_o = 16'h0000;
		data_o = 16'h0000;
	end
	always @(posedge mclk_i) begin
		#1;
		ph <= ph + 4'h1;
		aux_o <= ph[2];
		// idle strobe sits at the level chosen by the bench
		strobe_o <= active_i ? ph[1] : idle_lvl_i;
		addr_o <= 16'($urandom);
		data_o <= 16'($urandom);
	end
endmodule

// File: sim/auto_power_down_control_tb_top.sv
// Purpose: self-checking bench of the automatic power-down controller
// Assumes: 25 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   aux edges at the pin are counted to predict power-down entry
`timescale 1ns/100ps
module auto_power_down_control_tb_top;
	logic        mclk_i = 1'b0, rst_i = 1'b1, chip_sel_n_i = 1'b0;
	logic        addr_strobe_input_i, aux_clock_input_i, main_below_stby_i;
	logic        write_high_byte_strobe_i = 1'b0, apd_enable_i = 1'b0;
	logic        strobe_polarity_i = 1'b1, pmr0_wr_i = 1'b0, pmr2_wr_i = 1'b0;
	logic        data_oe_req_i = 1'b1, periph_oe_req_i = 1'b1, active = 1'b1;
	logic [2:0]  bus_control_inputs_i = 3'h0;
	logic [15:0] mcu_addr_i, mcu_data_i, mem_addr_o, mem_data_o;
	logic [7:0]  pmr0_data_i = 8'h00, pmr2_data_i = 8'h00;
	logic [7:0]  power_mode_reg_zero_o, power_mode_reg_two_o, pld_addr_lo_o;
	logic [3:0]  idle_count_o;
	logic [2:0]  pld_ctrl_o;
	logic        power_down_flag_o, full_speed_o, mem_sel_o, pld_strobe_o;
	logic        pld_wrh_o, pld_aux_array_o, pld_aux_mcell_o, data_port_oe_o;
	logic        periph_oe_o, battery_on_indicator_o, aux_prev = 1'b0, ok;
	int          bad_count = 0, check_count = 0, aux_n = 0, cyc_n = 0;
	logic [15:0] snap, snap_d;
	logic [2:0][31:0] ah;
	logic [7:0]  v;
	always #20 mclk_i = ~mclk_i;
	initial main_below_stby_i = 1'b0;
	apd_mcu_model mcu (.mclk_i, .active_i(active),
		.idle_lvl_i(strobe_polarity_i), .strobe_o(addr_strobe_input_i),
		.aux_o(aux_clock_input_i), .addr_o(mcu_addr_i), .data_o(mcu_data_i));
	apd_power_ctrl uut (.mclk_i, .rst_i, .addr_strobe_input_i,
		.aux_clock_input_i, .chip_sel_n_i, .bus_control_inputs_i,
		.write_high_byte_strobe_i, .mcu_addr_i, .mcu_data_i,
		.main_below_stby_i, .apd_enable_i, .strobe_polarity_i, .pmr0_wr_i,
		.pmr0_data_i, .pmr2_wr_i, .pmr2_data_i, .data_oe_req_i,
		.periph_oe_req_i, .power_down_flag_o, .idle_count_o,
		.power_mode_reg_zero_o, .power_mode_reg_two_o, .full_speed_o,
		.mem_addr_o, .mem_data_o, .mem_sel_o, .pld_addr_lo_o, .pld_ctrl_o,
		.pld_strobe_o, .pld_wrh_o, .pld_aux_array_o, .pld_aux_mcell_o,
		.data_port_oe_o, .periph_oe_o, .battery_on_indicator_o);
	// integer model of the idle link: aux periods seen at the pin
	always @(posedge mclk_i) begin
		aux_prev <= aux_clock_input_i;
		// pin bus history: memory path lags the pins by three edges
		ah <= {ah[1:0], mcu_addr_i, mcu_data_i};
		aux_n <= aux_n + int'(aux_clock_input_i & ~aux_prev);
		cyc_n <= cyc_n + 1;
		if (cyc_n == 30000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wr(logic two, logic [7:0] d);
		cyc(1);
		pmr0_wr_i = ~two;
		pmr2_wr_i = two;
		pmr0_data_i = d;
		pmr2_data_i = d;
		cyc(1);
		pmr0_wr_i = 1'b0;
		pmr2_wr_i = 1'b0;
		cyc(2);
	endtask
	task automatic wait_flag(logic lvl, output logic hit);
		hit = 1'b0;
		for (int i = 0; i < 400 && !hit; i++) begin
			cyc(1);
			hit = (power_down_flag_o === lvl);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h23fa));
		cyc(10);
		rst_i = 1'b0;
		check("reg0", power_mode_reg_zero_o, 16'h0000);
		check("full_speed", full_speed_o, 16'h0001);
		wr(1'b0, 8'h08);
		check("reg0", power_mode_reg_zero_o, 16'h0008);
		check("full_speed", full_speed_o, 16'h0000);
		wr(1'b0, 8'h00);
		check("full_speed", full_speed_o, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h20 : 8'h10;
			wr(1'b0, v);
			ok = 1'b0;
			for (int k = 0; k < 16; k++) begin
				cyc(1);
				check("aux_blocked", i ? pld_aux_mcell_o : pld_aux_array_o,
					16'h0000);
				ok |= (i ? pld_aux_array_o : pld_aux_mcell_o) === 1'b1;
			end
			check("aux_passes", ok, 16'h0001);
		end
		wr(1'b1, 8'h7d);
		check("reg2", power_mode_reg_two_o, 16'h007d);
		snap = {pld_addr_lo_o, pld_ctrl_o, pld_strobe_o, pld_wrh_o, 3'h0};
		for (int k = 0; k < 8; k++) begin
			bus_control_inputs_i = 3'($urandom);
			write_high_byte_strobe_i = 1'($urandom);
			cyc(2);
		end
		check("pld_blocked", {pld_addr_lo_o, pld_ctrl_o, pld_strobe_o,
			pld_wrh_o, 3'h0}, snap);
		bus_control_inputs_i = 3'h5;
		wr(1'b1, 8'h00);
		cyc(4);
		check("pld_ctrl", pld_ctrl_o, 16'h0005);
		check("mem_sel_on", mem_sel_o, 16'h0001);
		chip_sel_n_i = 1'b1;
		cyc(5);
		check("mem_sel", mem_sel_o, 16'h0000);
		check("data_oe", {data_port_oe_o, periph_oe_o}, 16'h0003);
		for (int k = 0; k < 4; k++) begin
			main_below_stby_i = 1'($urandom);
			cyc(5);
			check("battery", battery_on_indicator_o, main_below_stby_i);
		end
		active = 1'b0;
		cyc(200);
		check("idle_off", {power_down_flag_o, idle_count_o}, 16'h0000);
		apd_enable_i = 1'b1;
		active = 1'b1;
		cyc(200);
		check("pulsing", {power_down_flag_o, idle_count_o}, 16'h0000);
		check("mem_addr_live", mem_addr_o, ah[2][31:16]);
		check("mem_data_live", mem_data_o, ah[2][15:0]);
		for (int e = 0; e < 4; e++) begin
			v = (e == 1) ? 8'h38 : 8'h00;
			wr(1'b0, v);
			strobe_polarity_i = e[0];
			chip_sel_n_i = 1'b1;
			apd_enable_i = 1'b1;
			cyc(6);
			active = 1'b0;
			// count from the last possible strobe edge on
			aux_n = 0;
			cyc(4);
			wait_flag(1'b1, ok);
			check("entered", ok, 16'h0001);
			check("aux_periods", aux_n >= 15 && aux_n <= 16, 16'h0001);
			check("count", idle_count_o, 16'h000f);
			check("mem_sel", mem_sel_o, 16'h0000);
			check("oe", {data_port_oe_o, periph_oe_o}, 16'h0000);
			check("full_speed", full_speed_o, !v[3]);
			snap = mem_addr_o;
			snap_d = mem_data_o;
			cyc(10);
			check("mem_addr", mem_addr_o, snap);
			check("mem_data", mem_data_o, snap_d);
			case (e)
				0: active = 1'b1;
				1: chip_sel_n_i = 1'b0;
				2: rst_i = 1'b1;
				default: apd_enable_i = 1'b0;
			endcase
			wait_flag(1'b0, ok);
			check("exited", ok, 16'h0001);
			cyc(1);
			check("count_clr", idle_count_o, 16'h0000);
			check("mem_sel_exit", mem_sel_o, e == 1);
			rst_i = 1'b0;
			active = 1'b1;
			cyc(4);
		end
		conclude();
	end
endmodule
